// ### rtl/btc_core.v
// Contract
// - Bit test sets Z from inverted bit
// - Register target: long, bit number mod 32
// - Memory target: byte, bit number mod 8
// - Bit zero is least significant
// - Register-form bit test opcode decode
// - Immediate-form opcode and extension decode
// - Data modes only; immediate in register form
// - Effective-address mode field decoding
// - Signed upper bound; trap below zero/above
// - Single check flags: N set/cleared, X kept
// - Single check size field and register
// - Upper bound via any data mode
// - Pair check fetches lower then upper
// - Data register: low part compared only
// - Address register: bounds sign-extended
// - Pair check traps outside inclusive range
// - Pair flags: Z equal bound, C out
// - Pair opcode size and extension decode
// - Bounds only through control modes
`timescale 1ns/1ps
`include "btc_defines.vh"

module btc_core (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // Instruction stream
    input  wire        ins_valid,
    input  wire [15:0] ins_word,
    input  wire [15:0] ins_ext,
    output reg         ins_ready,
    // Register file read port
    output reg         rf_req,
    output reg  [3:0]  rf_sel,
    input  wire        rf_ack,
    input  wire [31:0] rf_data,
    // Operand bus
    output reg         mem_req,
    output reg  [2:0]  mem_mode,
    output reg  [2:0]  mem_reg,
    output reg  [1:0]  mem_size,
    output reg         mem_second,
    input  wire        mem_ack,
    input  wire [31:0] mem_data,
    // Condition codes and exception unit
    input  wire [4:0]  ccr_in,
    output reg  [4:0]  ccr_out,
    output reg         ccr_we,
    output reg         done,
    output reg         trap,
    output reg  [7:0]  trap_vec,
    output reg         bad_op,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr
);

    localparam S_IDLE = 3'h0;
    localparam S_RF1  = 3'h1;
    localparam S_RF2  = 3'h2;
    localparam S_MEM1 = 3'h3;
    localparam S_MEM2 = 3'h4;
    localparam S_EXEC = 3'h5;

    localparam OP_BT  = 2'h0;
    localparam OP_CK  = 2'h1;
    localparam OP_CK2 = 2'h2;

    reg [2:0]  state_q;
    reg [1:0]  op_q;
    reg [1:0]  size_q;
    reg [2:0]  mode_q;
    reg [2:0]  ear_q;
    reg        cls_q;
    reg [31:0] a_q;
    reg [31:0] b_q;
    reg [31:0] c_q;
    reg [31:0] ctrl_q;
    reg [15:0] traps_q;
    reg [4:0]  last_ccr_q;
    reg        last_trap_q;

    // Opcode fields
    wire [2:0] f_mode = ins_word[5:3];
    wire [2:0] f_reg  = ins_word[2:0];
    wire [2:0] f_dn   = ins_word[11:9];
    wire       m_ext  = (f_mode == `BTC_M_EXT);

    // Data modes, with and without immediate
    // mode field decode
    wire ext_ok  = (f_reg == `BTC_R_ABSW) || (f_reg == `BTC_R_ABSL) ||
                   (f_reg == `BTC_R_PCD)  || (f_reg == `BTC_R_PCX);
    wire data_nimm = (f_mode != `BTC_M_AREG) && (!m_ext || ext_ok);
    wire data_imm  = data_nimm || (m_ext && f_reg == `BTC_R_IMM);
    wire ctl_ok = (f_mode == `BTC_M_IND) || (f_mode == `BTC_M_DISP) ||
                  (f_mode == `BTC_M_IDX) || (m_ext && ext_ok);

    // Opcode recognition
    // register-form pattern
    wire is_btr = (ins_word[15:12] == 4'h0) &&
                  (ins_word[8:6] == `BTC_BTR_OPM);
    // immediate form with zero upper extension byte
    wire is_bti = (ins_word[15:6] == `BTC_BTI_HI) &&
                  (ins_ext[15:8] == 8'h00);
    // size field 11 word, 10 long
    wire is_chk = (ins_word[15:12] == `BTC_CHK_HI) && !ins_word[6] &&
                  ((ins_word[8:7] == `BTC_CHK_W) ||
                   (ins_word[8:7] == `BTC_CHK_L));
    // size 00/01/10, extension bit 11 set, bits 10:0 zero
    wire is_ck2 = (ins_word[15:11] == 5'h00) &&
                  (ins_word[10:9] != 2'h3) &&
                  (ins_word[8:6] == `BTC_CK2_OPM) &&
                  ((ins_ext[11:0] & 12'hFFF) == `BTC_CK2_EXT);

    // Legal combinations, gated by software enables
    // immediate target only in register form
    wire ok_btr = is_btr && data_imm && ctrl_q[0];
    wire ok_bti = is_bti && data_nimm && ctrl_q[0];
    wire ok_chk = is_chk && data_imm && ctrl_q[1];
    wire ok_ck2 = is_ck2 && ctl_ok && ctrl_q[2];
    wire take   = ins_valid && ins_ready;

    // Sign extension and mask by size
    function [31:0] sext;
        input [31:0] v;
        input [1:0]  s;
        begin
            if (s == `BTC_SZ_B) begin
                sext = {{24{v[7]}}, v[7:0]};
            end else if (s == `BTC_SZ_W) begin
                sext = {{16{v[15]}}, v[15:0]};
            end else begin
                sext = v;
            end
        end
    endfunction

    function [31:0] smask;
        input [1:0] s;
        begin
            if (s == `BTC_SZ_B) begin
                smask = 32'h0000_00FF;
            end else if (s == `BTC_SZ_W) begin
                smask = 32'h0000_FFFF;
            end else begin
                smask = 32'hFFFF_FFFF;
            end
        end
    endfunction

    // Execution datapath
    reg        bit_v;
    reg        ck_neg;
    reg        ck_gt;
    reg [31:0] k_m;
    reg [31:0] k_r;
    reg [31:0] k_lo;
    reg [31:0] k_hi;
    reg [31:0] k_d1;
    reg [31:0] k_d2;
    reg        ck2_out;
    reg        ck2_eq;
    reg [4:0]  ccr_d;
    reg        trap_d;

    always @* begin
        if (mode_q == `BTC_M_DREG) begin
            bit_v = b_q[a_q[4:0]];
        end else begin
            bit_v = b_q[a_q[2:0]];
        end
        // signed compare against zero and bound
        ck_neg = $signed(sext(a_q, size_q)) < 0;
        ck_gt  = $signed(sext(a_q, size_q)) > $signed(sext(b_q, size_q));
        k_m  = cls_q ? 32'hFFFF_FFFF : smask(size_q);
        k_r  = cls_q ? a_q : (a_q & k_m);
        k_lo = cls_q ? sext(b_q, size_q) : (b_q & k_m);
        k_hi = cls_q ? sext(c_q, size_q) : (c_q & k_m);
        // inclusive range, equal bounds allow one value
        k_d1 = (k_r - k_lo) & k_m;
        k_d2 = (k_hi - k_lo) & k_m;
        ck2_out = k_d1 > k_d2;
        ck2_eq  = (k_r == k_lo) || (k_r == k_hi);
        ccr_d  = ccr_in;
        trap_d = 1'b0;
        case (op_q)
            OP_BT: begin
                ccr_d[`BTC_F_Z] = ~bit_v;
            end
            OP_CK: begin
                // N set below zero, else cleared; Z V C zero
                ccr_d[3:0] = {ck_neg, 3'h0};
                trap_d = ck_neg || ck_gt;
            end
            default: begin
                // Z equal to a bound, C out of range
                ccr_d[3:0] = 4'h0;
                ccr_d[`BTC_F_Z] = ck2_eq;
                ccr_d[`BTC_F_C] = ck2_out;
                trap_d = ck2_out;
            end
        endcase
    end

    // Sequencer: decode, register and operand fetch, execute
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q    <= S_IDLE;
            op_q       <= OP_BT;
            size_q     <= `BTC_SZ_L;
            mode_q     <= 3'h0;
            ear_q      <= 3'h0;
            cls_q      <= 1'b0;
            a_q        <= 32'h0;
            b_q        <= 32'h0;
            c_q        <= 32'h0;
            ins_ready  <= 1'b0;
            rf_req     <= 1'b0;
            rf_sel     <= 4'h0;
            mem_req    <= 1'b0;
            mem_mode   <= 3'h0;
            mem_reg    <= 3'h0;
            mem_size   <= `BTC_SZ_B;
            mem_second <= 1'b0;
            ccr_out    <= 5'h0;
            ccr_we     <= 1'b0;
            done       <= 1'b0;
            trap       <= 1'b0;
            trap_vec   <= 8'h0;
            bad_op     <= 1'b0;
            traps_q    <= 16'h0;
            last_ccr_q <= 5'h0;
            last_trap_q <= 1'b0;
        end else begin
            done   <= 1'b0;
            trap   <= 1'b0;
            ccr_we <= 1'b0;
            bad_op <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    ins_ready <= 1'b1;
                    if (take) begin
                        mode_q <= f_mode;
                        ear_q  <= f_reg;
                        cls_q  <= 1'b0;
                        ins_ready <= 1'b0;
                        if (ok_btr || ok_chk) begin
                            // First read: bit number or checked value
                            op_q   <= ok_btr ? OP_BT : OP_CK;
                            size_q <= (ok_chk && ins_word[7]) ?
                                      `BTC_SZ_W : `BTC_SZ_L;
                            rf_sel <= {1'b0, f_dn};
                            rf_req <= 1'b1;
                            state_q <= S_RF1;
                        end else if (ok_bti) begin
                            op_q   <= OP_BT;
                            size_q <= `BTC_SZ_L;
                            a_q    <= {24'h0, ins_ext[7:0]};
                            if (f_mode == `BTC_M_DREG) begin
                                rf_sel  <= {1'b0, f_reg};
                                rf_req  <= 1'b1;
                                state_q <= S_RF2;
                            end else begin
                                mem_mode <= f_mode;
                                mem_reg  <= f_reg;
                                mem_size <= `BTC_SZ_B;
                                mem_second <= 1'b0;
                                mem_req  <= 1'b1;
                                state_q  <= S_MEM1;
                            end
                        end else if (ok_ck2) begin
                            op_q   <= OP_CK2;
                            size_q <= ins_word[10:9];
                            cls_q  <= ins_ext[15];
                            rf_sel <= ins_ext[15:12];
                            rf_req <= 1'b1;
                            state_q <= S_RF1;
                        end else begin
                            // Unknown or illegal form
                            bad_op    <= 1'b1;
                            ins_ready <= 1'b1;
                        end
                    end
                end
                S_RF1: begin
                    if (rf_ack) begin
                        a_q    <= rf_data;
                        rf_req <= 1'b0;
                        if (op_q != OP_CK2 && mode_q == `BTC_M_DREG) begin
                            rf_sel  <= {1'b0, ear_q};
                            state_q <= S_RF2;
                        end else begin
                            // Memory target byte; bound at check size
                            mem_mode <= mode_q;
                            mem_reg  <= ear_q;
                            mem_size <= (op_q == OP_BT) ? `BTC_SZ_B : size_q;
                            mem_second <= 1'b0;
                            mem_req  <= 1'b1;
                            state_q  <= S_MEM1;
                        end
                    end
                end
                S_RF2: begin
                    rf_req <= 1'b1;
                    if (rf_req && rf_ack) begin
                        b_q     <= rf_data;
                        rf_req  <= 1'b0;
                        state_q <= S_EXEC;
                    end
                end
                S_MEM1: begin
                    if (mem_ack) begin
                        b_q <= mem_data;
                        if (op_q == OP_CK2) begin
                            mem_second <= 1'b1;
                            state_q    <= S_MEM2;
                        end else begin
                            mem_req <= 1'b0;
                            state_q <= S_EXEC;
                        end
                    end
                end
                S_MEM2: begin
                    if (mem_ack) begin
                        c_q        <= mem_data;
                        mem_req    <= 1'b0;
                        mem_second <= 1'b0;
                        state_q    <= S_EXEC;
                    end
                end
                default: begin
                    // Result, flags and exception hand-over
                    ccr_out    <= ccr_d;
                    ccr_we     <= 1'b1;
                    last_ccr_q <= ccr_d;
                    last_trap_q <= trap_d;
                    // vector 6 instead of normal completion
                    if (trap_d) begin
                        trap     <= 1'b1;
                        trap_vec <= `BTC_TRAP_VEC;
                        traps_q  <= traps_q + 16'h1;
                    end else begin
                        done <= 1'b1;
                    end
                    ins_ready <= 1'b1;
                    state_q   <= S_IDLE;
                end
            endcase
        end
    end

    // APB slave: one wait state, write lands with pready
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_q  <= `BTC_CTRL_RST;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                pready <= 1'b1;
                if (paddr == `BTC_OFS_CTRL) begin
                    prdata <= ctrl_q;
                end else if (paddr == `BTC_OFS_STAT) begin
                    prdata <= {20'h0, last_trap_q, last_ccr_q,
                               op_q, 1'b0, state_q};
                end else if (paddr == `BTC_OFS_TRAPS) begin
                    prdata <= {16'h0, traps_q};
                end else begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;
                end
            end
            if (psel && penable && pready && pwrite &&
                paddr == `BTC_OFS_CTRL) begin
                ctrl_q <= {29'h0, pwdata[2:0]};
            end
        end
    end

endmodule

// ### rtl/btc_defines.vh
`ifndef BTC_DEFINES_VH
`define BTC_DEFINES_VH

// Register byte offsets
`define BTC_OFS_CTRL      12'h000
`define BTC_OFS_STAT      12'h004
`define BTC_OFS_TRAPS     12'h008
`define BTC_CTRL_RST      32'h0000_0007

// Exception vector for out-of-range checks
`define BTC_TRAP_VEC      8'h06

// Effective-address modes and mode 111 sub-codes
`define BTC_M_DREG        3'h0
`define BTC_M_AREG        3'h1
`define BTC_M_IND         3'h2
`define BTC_M_POST        3'h3
`define BTC_M_PRE         3'h4
`define BTC_M_DISP        3'h5
`define BTC_M_IDX         3'h6
`define BTC_M_EXT         3'h7
`define BTC_R_ABSW        3'h0
`define BTC_R_ABSL        3'h1
`define BTC_R_PCD         3'h2
`define BTC_R_PCX         3'h3
`define BTC_R_IMM         3'h4

// Operand sizes
`define BTC_SZ_B          2'h0
`define BTC_SZ_W          2'h1
`define BTC_SZ_L          2'h2

// Opcode patterns
`define BTC_BTR_OPM       3'h4
`define BTC_BTI_HI        10'h020
`define BTC_CHK_HI        4'h4
`define BTC_CHK_W         2'h3
`define BTC_CHK_L         2'h2
`define BTC_CK2_OPM       3'h3
`define BTC_CK2_EXT       12'h800

// Flag positions in the condition byte: X N Z V C
`define BTC_F_N           3
`define BTC_F_Z           2
`define BTC_F_C           0

`endif

// ### testbench/btc_chk.sv
`timescale 1ns/1ps
module btc_chk (
    // Clock and reset
    input logic        ref_clk,
    input logic        rst_b,
    // Instruction stream
    input logic        ins_valid,
    input logic        ins_ready,
    input logic [15:0] ins_word,
    // Operand bus
    input logic        mem_req,
    input logic        mem_ack,
    input logic [1:0]  mem_size,
    input logic        mem_second,
    // Flags and results
    input logic [4:0]  ccr_in,
    input logic [4:0]  ccr_out,
    input logic        ccr_we,
    input logic        done,
    input logic        trap,
    input logic [7:0]  trap_vec,
    input logic        bad_op
);
    logic [1:0] kind_q;
    wire        take = ins_valid && ins_ready;
    wire        pair = ins_word[15:11] == 5'h00 && ins_word[8:6] == 3'h3;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Last operation taken: 1 bit test, 2 single check, 3 pair check
    always @(posedge ref_clk) begin
        if (!rst_b)
            kind_q <= 2'h0;
        else if (take)
            kind_q <= ins_word[15:12] == 4'h4 ? 2'h2 :
                      pair ? 2'h3 : ins_word[15:12] == 4'h0 ? 2'h1 : 2'h0;
    end
    a_trap_vec_six: assert property (trap |-> trap_vec == 8'h06)
        else $error("trap without vector six");
    a_flags_with_end: assert property (ccr_we == (done || trap))
        else $error("flag write apart from completion");
    a_extend_kept: assert property (ccr_we |->
        ccr_out[4] == ccr_in[4])
        else $error("extend flag changed");
    a_bit_test_keep: assert property (ccr_we && kind_q == 2'h1 |->
        {ccr_out[4:3], ccr_out[1:0]} == {ccr_in[4:3], ccr_in[1:0]})
        else $error("bit test touched other flags");
    a_bit_no_trap: assert property (kind_q == 2'h1 |-> !trap)
        else $error("bit test trapped");
    a_bit_byte_read: assert property (mem_req && kind_q == 2'h1 |->
        mem_size == 2'h0) else $error("bit test memory read not a byte");
    a_pair_carry: assert property (ccr_we && kind_q == 2'h3 |->
        ccr_out[0] == trap) else $error("carry disagrees with trap");
    a_areg_refused: assert property (take && ins_word[5:3] == 3'h1 |=>
        bad_op) else $error("pointer register operand accepted");
    a_lower_first: assert property ($rose(mem_req) |-> !mem_second)
        else $error("upper bound fetched first");
    a_operand_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_size)) else $error("operand request dropped");
    c_trap: cover property (trap);
    c_pair_done: cover property (done && kind_q == 2'h3);
    c_refused: cover property (bad_op);
endmodule

bind btc_core btc_chk i_btc_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .ins_valid(ins_valid),
    .ins_ready(ins_ready), .ins_word(ins_word), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_size(mem_size), .mem_second(mem_second),
    .ccr_in(ccr_in), .ccr_out(ccr_out), .ccr_we(ccr_we), .done(done),
    .trap(trap), .trap_vec(trap_vec), .bad_op(bad_op)
);

// ### testbench/btc_mdl.sv
`timescale 1ns/1ps
module btc_mdl (
    // Clock and reset
    input  logic        ref_clk,
    input  logic        rst_b,
    // Register file
    input  logic        rf_req,
    input  logic [3:0]  rf_sel,
    output logic        rf_ack,
    output logic [31:0] rf_data,
    // Operand bus and bound values
    input  logic        mem_req,
    input  logic [2:0]  mem_mode,
    input  logic [2:0]  mem_reg,
    input  logic        mem_second,
    output logic        mem_ack,
    output logic [31:0] mem_data,
    input  logic [31:0] bnd_lo,
    input  logic [31:0] bnd_hi,
    input  logic [1:0]  lat
);
    logic [31:0] regs [0:15];
    logic [5:0]  last_ea;
    logic [3:0]  cnt_q;
    // Answer after lat cycles; idle data lines toggle so stale data shows
    always @(posedge ref_clk) begin
        rf_ack <= 1'b0;
        mem_ack <= 1'b0;
        rf_data <= ~rf_data;
        mem_data <= ~mem_data;
        cnt_q <= cnt_q + 4'h1;
        if (!rst_b) begin
            rf_data <= 32'h0000_0000;
            mem_data <= 32'h0000_0000;
            cnt_q <= 4'h0;
        end else if (!(rf_req || mem_req)) begin
            cnt_q <= 4'h0;
        end else if (rf_req && !rf_ack && cnt_q >= lat) begin
            rf_ack <= 1'b1;
            rf_data <= regs[rf_sel];
            cnt_q <= 4'h0;
        end else if (mem_req && !mem_ack && cnt_q >= lat) begin
            mem_ack <= 1'b1;
            mem_data <= mem_second ? bnd_hi : bnd_lo;
            last_ea <= {mem_mode, mem_reg};
            cnt_q <= 4'h0;
        end
    end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam [2:0] OK = 3'h4;
    localparam [2:0] TR = 3'h2;
    localparam [2:0] BAD = 3'h1;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ins_valid = 1'b0;
    logic [15:0] ins_word = 16'h0000;
    logic [15:0] ins_ext = 16'h0000;
    logic [4:0]  ccr_in = 5'h1B;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] bnd_lo = 32'h0000_0000;
    logic [31:0] bnd_hi = 32'h0000_0000;
    logic [1:0]  lat = 2'h0;
    logic [31:0] rd;
    logic        er;
    logic        ok;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          n_trap = 0;
    wire         ins_ready, rf_req, rf_ack, mem_req, mem_second, mem_ack;
    wire         ccr_we, done, trap, bad_op, pready, pslverr;
    wire [3:0]   rf_sel;
    wire [2:0]   mem_mode, mem_reg;
    wire [1:0]   mem_size;
    wire [4:0]   ccr_out;
    wire [7:0]   trap_vec;
    wire [31:0]  rf_data, mem_data, prdata;
    // Core clock
    always #25 ref_clk = ~ref_clk;
    btc_core i_btc_core (
        .ref_clk(ref_clk), .rst_b(rst_b), .ins_valid(ins_valid),
        .ins_word(ins_word), .ins_ext(ins_ext), .ins_ready(ins_ready),
        .rf_req(rf_req), .rf_sel(rf_sel), .rf_ack(rf_ack), .rf_data(rf_data),
        .mem_req(mem_req), .mem_mode(mem_mode), .mem_reg(mem_reg),
        .mem_size(mem_size), .mem_second(mem_second), .mem_ack(mem_ack),
        .mem_data(mem_data), .ccr_in(ccr_in), .ccr_out(ccr_out),
        .ccr_we(ccr_we), .done(done), .trap(trap), .trap_vec(trap_vec),
        .bad_op(bad_op), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    btc_mdl i_btc_mdl (
        .ref_clk(ref_clk), .rst_b(rst_b), .rf_req(rf_req), .rf_sel(rf_sel),
        .rf_ack(rf_ack), .rf_data(rf_data), .mem_req(mem_req),
        .mem_mode(mem_mode), .mem_reg(mem_reg), .mem_second(mem_second),
        .mem_ack(mem_ack), .mem_data(mem_data), .bnd_lo(bnd_lo),
        .bnd_hi(bnd_hi), .lat(lat));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic no_answer;
        n_mismatch++;
        $display("mismatch at %0t: no answer", $time);
        end_of_test;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge ref_clk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) no_answer;
    endtask
    // Offer one instruction and judge its completion
    task automatic run(input logic [15:0] w, input logic [15:0] e,
                       input logic [2:0] res, input logic [4:0] f);
        @(posedge ref_clk);
        ins_valid <= 1'b1;
        ins_word <= w;
        ins_ext <= e;
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge ref_clk);
            ok = (ins_ready === 1'b1);
        end
        ins_valid <= 1'b0;
        if (!ok) no_answer;
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge ref_clk);
            ok = ((done | trap | bad_op) === 1'b1);
        end
        if (!ok) no_answer;
        chk({done, trap, bad_op}, res);
        if (res != BAD) chk({ccr_we, ccr_out}, {1'b1, f});
        if (res == TR) chk(trap_vec, 8'h06);
        if (res == TR) n_trap++;
    endtask
    // Bit test or single check: D1 value, D2 and memory operand b
    task automatic ck(input logic [15:0] w, input logic [15:0] e,
        input logic [31:0] r, input logic [31:0] b, input logic [2:0] res,
        input logic [4:0] f);
        i_btc_mdl.regs[1] <= r;
        i_btc_mdl.regs[2] <= b;
        bnd_lo <= b;
        run(w, e, res, f);
    endtask
    // Pair check on register 3 of either class
    task automatic c2(input logic [15:0] w, input logic [15:0] e,
        input logic [31:0] r, input logic [31:0] lo, input logic [31:0] hi,
        input logic [2:0] res, input logic [4:0] f);
        i_btc_mdl.regs[3] <= r;
        i_btc_mdl.regs[11] <= r;
        bnd_lo <= lo;
        bnd_hi <= hi;
        run(w, e, res, f);
    endtask
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0007);
        apb(1'b0, 12'h00C, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 12'h000, 32'h0000_0006);
        run(16'h0302, 16'h0000, BAD, 5'h00);
        apb(1'b1, 12'h000, 32'h0000_0001);
        ck(16'h433C, 16'h0, 0, 0, BAD, 5'h00);
        c2(16'h04D0, 16'h3800, 0, 0, 0, BAD, 5'h00);
        apb(1'b1, 12'h000, 32'h0000_0007);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0007);
        $display("t_regs done");
    endtask
    task automatic t_bit;
        logic [5:0] ea [9] = '{6'o20, 6'o30, 6'o40, 6'o50, 6'o60,
                               6'o70, 6'o71, 6'o72, 6'o73};
        ck(16'h0302, 16'h0, 31, 32'h8000_0010, OK, 5'h1B);
        ck(16'h0302, 16'h0, 0, 32'h8000_0010, OK, 5'h1F);
        ck(16'h0302, 16'h0, 36, 32'h8000_0010, OK, 5'h1B);
        ck(16'h0302, 16'h0, 33, 32'h8000_0010, OK, 5'h1F);
        lat <= 2'h2;
        ck(16'h0802, 16'h0024, 0, 32'h8000_0010, OK, 5'h1B);
        ck(16'h0810, 16'h0009, 0, 32'h0000_0102, OK, 5'h1B);
        ck(16'h0810, 16'h0008, 0, 32'h0000_0102, OK, 5'h1F);
        ck(16'h033C, 16'h0, 10, 32'h0000_0102, OK, 5'h1F);
        ck(16'h083C, 16'h0001, 0, 0, BAD, 5'h00);
        ck(16'h030A, 16'h0, 0, 0, BAD, 5'h00);
        ccr_in <= 5'h04;
        ck(16'h0302, 16'h0, 31, 32'h8000_0010, OK, 5'h00);
        ccr_in <= 5'h1B;
        foreach (ea[i]) begin
            ck({10'h020, ea[i]}, 16'h1, 0, 32'h102, OK, 5'h1B);
            chk(i_btc_mdl.last_ea, ea[i]);
        end
        $display("t_bit done");
    endtask
    task automatic t_chk;
        ck(16'h433C, 16'h0, 32'hFFFF_FFFF, 100, TR, 5'h18);
        ck(16'h433C, 16'h0, 101, 100, TR, 5'h10);
        ck(16'h433C, 16'h0, 100, 100, OK, 5'h10);
        ck(16'h433C, 16'h0, 5, 32'hFFFF_FFFF, TR, 5'h10);
        ck(16'h43BC, 16'h0, 32'h0001_0050, 100, OK, 5'h10);
        ck(16'h43BC, 16'h0, 32'h0000_8000, 100, TR, 5'h18);
        ck(16'h4382, 16'h0, 50, 100, OK, 5'h10);
        ck(16'h438A, 16'h0, 0, 0, BAD, 5'h00);
        $display("t_chk done");
    endtask
    task automatic t_pair;
        lat <= 2'h1;
        c2(16'h04D0, 16'h3800, 10, 10, 20, OK, 5'h14);
        c2(16'h04D0, 16'h3800, 20, 10, 20, OK, 5'h14);
        c2(16'h04D0, 16'h3800, 15, 10, 20, OK, 5'h10);
        c2(16'h04D0, 16'h3800, 21, 10, 20, TR, 5'h11);
        c2(16'h04D0, 16'h3800, 9, 10, 20, TR, 5'h11);
        c2(16'h04D0, 16'h3800, 6, 5, 5, TR, 5'h11);
        c2(16'h00D0, 16'h3800, 32'h1234_5606, 5, 7, OK, 5'h10);
        c2(16'h02D0, 16'hB800, -16, 32'hFFF0, 16, OK, 5'h14);
        c2(16'h02D0, 16'hB800, 32'hFFF0, 32'hFFF0, 16, TR, 5'h11);
        c2(16'h02D0, 16'h3800, 32'hFFF0, 32'hFFF0, 16, OK, 5'h14);
        c2(16'h04E8, 16'h3800, 32'h7, 1, 32'h8000_0000, OK, 5'h10);
        c2(16'h04E0, 16'h3800, 0, 0, 0, BAD, 5'h00);
        c2(16'h04FC, 16'h3800, 0, 0, 0, BAD, 5'h00);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, n_trap);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0420);
        $display("t_pair done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Reset, then each scenario in turn
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_regs;
        t_bit;
        t_chk;
        t_pair;
        end_of_test;
    end
endmodule
